// ---- verilog/slr_load_unit.sv ----
// Summary of operation
// - immediate string load fills target onward, leftmost byte first, wrapping 31 to 0
// - immediate string address is base contents, or zero when base field is zero
// - immediate byte count is the field, with zero meaning 32 bytes
// - registers written equal byte count over four, rounded up
// - legacy immediate form zero-fills unloaded right bytes of the last register
// - legacy immediate form never overwrites a nonzero base inside the range
// - immediate string loads leave exception register and condition field zero alone
// - a storage fault aborts the string load; it restarts from the first byte
// - indexed address is base plus index, or index alone when base field is zero
// - indexed byte count comes from exception register bits 25 to 31
// - indexed load with zero count leaves the target register untouched
// - legacy indexed form skips base and index registers inside the range only when the base field is nonzero
// - legacy indexed form zero-fills unloaded right bytes of the last register
// - sign-extending word load puts word low and copies its sign bit high
// - sign-extending word load on a 32-bit build raises illegal instruction
// - reserve load address is index alone, or base plus index
// - reserve load writes the word and sets a reservation on its location
// - conditional store succeeds only if reserved location stayed unmodified
module slr_load_unit #(
    parameter int AW = 64,
    parameter bit IS_64BIT = 1'b1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // instruction from the core
    input wire logic cmd_valid_in,
    input wire slr_pkg::slr_cmd_t cmd_in,
    input wire logic [AW-1:0] base_val_in,
    input wire logic [AW-1:0] index_val_in,
    output logic cmd_ready_out,
    // storage access
    output logic mem_req_valid_out,
    output logic [AW-1:0] mem_req_addr_out,
    output slr_pkg::slr_size_t mem_req_size_out,
    input wire logic mem_req_ready_in,
    input wire logic mem_rsp_valid_in,
    input wire logic [slr_pkg::WORD_W-1:0] mem_rsp_data_in,
    input wire logic mem_rsp_fault_in,
    // register write-back
    output slr_pkg::slr_wb_t wb_out,
    // completion and exceptions
    output logic done_out,
    output logic illegal_out,
    output logic storage_fault_out,
    // reservation and conditional store check
    input wire logic snoop_valid_in,
    input wire logic [AW-1:0] snoop_addr_in,
    input wire logic cond_valid_in,
    input wire logic [AW-1:0] cond_addr_in,
    output logic resv_valid_out,
    output logic [AW-1:0] resv_addr_out,
    output logic cond_done_out,
    output logic cond_ok_out
);

    typedef enum logic [1:0] {
        SLR_ST_IDLE,
        SLR_ST_REQ,
        SLR_ST_WAIT
    } slr_state_t;

    slr_state_t state_ff;
    slr_pkg::slr_cmd_t cmd_ff;
    logic [AW-1:0] addr_ff;
    logic [AW-1:0] nxt_addr;
    logic [AW-1:0] base_or_zero;
    logic [AW-1:0] disp_ext;
    logic [slr_pkg::COUNT_W-1:0] left_ff;
    logic [slr_pkg::COUNT_W-1:0] nxt_count;
    logic [slr_pkg::LANE_W-1:0] lane_ff;
    logic [slr_pkg::REG_NUM_W-1:0] dest_ff;
    logic [slr_pkg::WORD_W-1:0] acc_ff;
    logic [slr_pkg::WORD_W-1:0] nxt_acc;
    logic is_string;
    logic last_byte;
    logic reg_full;
    logic dest_protected;
    logic rsp_ok;
    logic rsp_fault;
    logic cmd_take;
    logic cmd_illegal;
    logic cmd_empty;
    logic ready_ff;
    logic mem_valid_ff;
    slr_pkg::slr_wb_t wb_ff;
    logic done_ff;
    logic illegal_ff;
    logic fault_ff;
    logic resv_set;
    slr_pkg::slr_size_t size_ff;

    assign cmd_take = cmd_valid_in && ready_ff;
    assign base_or_zero = (cmd_in.base_reg_field != slr_pkg::REG_ZERO) ? base_val_in : '0;
    assign disp_ext = AW'($signed(cmd_in.disp));
    assign cmd_illegal = (cmd_in.op == slr_pkg::SLR_OP_WORD_ALG) && !IS_64BIT;

    // effective address and byte count per instruction kind
    always_comb begin
        nxt_addr = base_or_zero + index_val_in;
        nxt_count = slr_pkg::COUNT_ZERO;
        case (cmd_in.op)
            slr_pkg::SLR_OP_STR_IMM: begin
                nxt_addr = base_or_zero;
                if (cmd_in.byte_count_field == slr_pkg::BCF_FIELD_ZERO) begin
                    nxt_count = slr_pkg::BCF_ZERO_COUNT;
                end else begin
                    nxt_count = slr_pkg::COUNT_W'(cmd_in.byte_count_field);
                end
            end
            slr_pkg::SLR_OP_STR_IDX: begin
                nxt_count = cmd_in.fixed_point_exception_reg[slr_pkg::FXR_CNT_LSB +: slr_pkg::COUNT_W];
            end
            slr_pkg::SLR_OP_WORD_ALG: begin
                nxt_addr = base_or_zero + disp_ext;
            end
            default: begin
            end
        endcase
    end

    assign cmd_empty = (cmd_in.op == slr_pkg::SLR_OP_STR_IDX) && (nxt_count == slr_pkg::COUNT_ZERO);

    assign is_string = (cmd_ff.op == slr_pkg::SLR_OP_STR_IMM) || (cmd_ff.op == slr_pkg::SLR_OP_STR_IDX);
    assign rsp_ok = (state_ff == SLR_ST_WAIT) && mem_rsp_valid_in && !mem_rsp_fault_in;
    assign rsp_fault = (state_ff == SLR_ST_WAIT) && mem_rsp_valid_in && mem_rsp_fault_in;
    assign last_byte = (left_ff == slr_pkg::COUNT_ONE);
    // a register is written once its fourth lane fills or the string ends
    assign reg_full = (lane_ff == slr_pkg::LANE_LAST) || last_byte;

    // legacy forms keep address registers that fall inside the range when the base field is nonzero
    always_comb begin
        dest_protected = 1'b0;
        if (cmd_ff.legacy && (cmd_ff.base_reg_field != slr_pkg::REG_ZERO)) begin
            if (dest_ff == cmd_ff.base_reg_field) begin
                dest_protected = 1'b1;
            end
            if ((cmd_ff.op == slr_pkg::SLR_OP_STR_IDX) && (dest_ff == cmd_ff.index_reg_field)) begin
                dest_protected = 1'b1;
            end
        end
    end

    // byte lane k%4 counted from the most significant end
    always_comb begin
        nxt_acc = acc_ff;
        nxt_acc[(slr_pkg::WORD_W - slr_pkg::BYTE_W) - (slr_pkg::BYTE_W * lane_ff) +: slr_pkg::BYTE_W] =
            mem_rsp_data_in[slr_pkg::BYTE_W-1:0];
    end

    // sequencer
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff <= SLR_ST_IDLE;
        end else begin
            case (state_ff)
                SLR_ST_IDLE: begin
                    if (cmd_take && !cmd_illegal && !cmd_empty) begin
                        state_ff <= SLR_ST_REQ;
                    end
                end
                SLR_ST_REQ: begin
                    if (mem_req_ready_in) begin
                        state_ff <= SLR_ST_WAIT;
                    end
                end
                SLR_ST_WAIT: begin
                    if (rsp_fault) begin
                        state_ff <= SLR_ST_IDLE;
                    end else if (rsp_ok) begin
                        state_ff <= (is_string && !last_byte) ? SLR_ST_REQ : SLR_ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= SLR_ST_IDLE;
                end
            endcase
        end
    end

    // command capture and string progress
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmd_ff <= '0;
            addr_ff <= '0;
            left_ff <= slr_pkg::COUNT_ZERO;
            lane_ff <= '0;
            dest_ff <= slr_pkg::REG_ZERO;
            size_ff <= slr_pkg::SLR_SIZE_BYTE;
        end else if (cmd_take) begin
            size_ff <= slr_pkg::slr_size_t'(cmd_in.op[1]);
            cmd_ff <= cmd_in;
            addr_ff <= nxt_addr;
            left_ff <= nxt_count;
            lane_ff <= '0;
            dest_ff <= cmd_in.target_reg_field;
        end else if (rsp_ok && is_string) begin
            addr_ff <= addr_ff + AW'(1);
            left_ff <= left_ff - slr_pkg::COUNT_ONE;
            lane_ff <= lane_ff + slr_pkg::LANE_W'(1);
            if (lane_ff == slr_pkg::LANE_LAST) begin
                dest_ff <= dest_ff + slr_pkg::REG_NUM_W'(1); // five-bit wrap from 31 to 0
            end
        end
    end

    // unfilled lanes read zero
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc_ff <= slr_pkg::WORD_ZERO;
        end else if (cmd_take || rsp_fault) begin
            acc_ff <= slr_pkg::WORD_ZERO;
        end else if (rsp_ok && is_string) begin
            acc_ff <= reg_full ? slr_pkg::WORD_ZERO : nxt_acc;
        end
    end

    // storage request
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mem_valid_ff <= 1'b0;
        end else if (cmd_take && !cmd_illegal && !cmd_empty) begin
            mem_valid_ff <= 1'b1;
        end else if (mem_valid_ff && mem_req_ready_in) begin
            mem_valid_ff <= 1'b0;
        end else if (rsp_ok && is_string && !last_byte) begin
            mem_valid_ff <= 1'b1;
        end
    end

    // register write-back; only general registers are ever written
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wb_ff <= '0;
        end else begin
            wb_ff.valid <= 1'b0;
            if (rsp_ok) begin
                case (cmd_ff.op)
                    slr_pkg::SLR_OP_STR_IMM, slr_pkg::SLR_OP_STR_IDX: begin
                        // last partial register keeps zero right lanes
                        wb_ff.valid <= reg_full && !dest_protected;
                        wb_ff.general_register <= dest_ff;
                        wb_ff.data <= {{(64 - slr_pkg::WORD_W){1'b0}}, nxt_acc};
                    end
                    slr_pkg::SLR_OP_WORD_ALG: begin
                        wb_ff.valid <= 1'b1;
                        wb_ff.general_register <= cmd_ff.target_reg_field;
                        wb_ff.data <= {{(64 - slr_pkg::WORD_W){mem_rsp_data_in[slr_pkg::WORD_W-1]}},
                            mem_rsp_data_in};
                    end
                    default: begin
                        wb_ff.valid <= 1'b1;
                        wb_ff.general_register <= cmd_ff.target_reg_field;
                        wb_ff.data <= {{(64 - slr_pkg::WORD_W){1'b0}}, mem_rsp_data_in};
                    end
                endcase
            end
        end
    end

    // completion and handshake
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_ff <= 1'b0;
            illegal_ff <= 1'b0;
            fault_ff <= 1'b0;
            ready_ff <= 1'b0;
        end else begin
            done_ff <= (cmd_take && cmd_empty && !cmd_illegal) || (rsp_ok && (!is_string || last_byte));
            illegal_ff <= cmd_take && cmd_illegal;
            // fault reported; core reissues the whole instruction
            fault_ff <= rsp_fault;
            ready_ff <= (state_ff == SLR_ST_IDLE) && !cmd_take;
        end
    end

    assign resv_set = rsp_ok && (cmd_ff.op == slr_pkg::SLR_OP_WORD_RSV);

    slr_reserve #(
        .AW(AW)
    ) u_reserve (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .set_in(resv_set),
        .set_addr_in(addr_ff),
        .snoop_valid_in(snoop_valid_in),
        .snoop_addr_in(snoop_addr_in),
        .cond_valid_in(cond_valid_in),
        .cond_addr_in(cond_addr_in),
        .resv_valid_out(resv_valid_out),
        .resv_addr_out(resv_addr_out),
        .cond_done_out(cond_done_out),
        .cond_ok_out(cond_ok_out)
    );

    assign cmd_ready_out = ready_ff;
    assign mem_req_valid_out = mem_valid_ff;
    assign mem_req_addr_out = addr_ff;
    assign mem_req_size_out = size_ff;
    assign wb_out = wb_ff;
    assign done_out = done_ff;
    assign illegal_out = illegal_ff;
    assign storage_fault_out = fault_ff;

endmodule // slr_load_unit

// ---- verilog/slr_pkg.sv ----
package slr_pkg;

    localparam int REG_NUM_W = 5;
    localparam int COUNT_W = 7;
    localparam int BCF_W = 5;
    localparam int DISP_W = 16;
    localparam int WORD_W = 32;
    localparam int BYTE_W = 8;
    localparam int LANE_W = 2;

    // a zero byte-count field on the immediate form means a full 32 bytes
    localparam logic [COUNT_W-1:0] BCF_ZERO_COUNT = 7'h20;
    localparam logic [BCF_W-1:0] BCF_FIELD_ZERO = 5'h00;
    localparam logic [REG_NUM_W-1:0] REG_ZERO = 5'h00;
    localparam logic [LANE_W-1:0] LANE_LAST = 2'h3;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 7'h00;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 7'h01;
    // count field: bits 25..31 msb-0, the low seven bits
    localparam int FXR_CNT_LSB = 0;
    localparam int FXR_W = 32;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        SLR_OP_STR_IMM,
        SLR_OP_STR_IDX,
        SLR_OP_WORD_ALG,
        SLR_OP_WORD_RSV
    } slr_op_t;

    typedef enum logic {
        SLR_SIZE_BYTE,
        SLR_SIZE_WORD
    } slr_size_t;

    typedef struct packed {
        slr_op_t op;
        logic legacy;
        logic [REG_NUM_W-1:0] target_reg_field;
        logic [REG_NUM_W-1:0] base_reg_field;
        logic [REG_NUM_W-1:0] index_reg_field;
        logic [BCF_W-1:0] byte_count_field;
        logic [DISP_W-1:0] disp;
        logic [FXR_W-1:0] fixed_point_exception_reg;
    } slr_cmd_t;

    typedef struct packed {
        logic valid;
        logic [REG_NUM_W-1:0] general_register;
        logic [63:0] data;
    } slr_wb_t;

endpackage

// ---- verilog/slr_reserve.sv ----
module slr_reserve #(
    parameter int AW = 64
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // reservation set from the word load
    input wire logic set_in,
    input wire logic [AW-1:0] set_addr_in,
    // modification of storage by any other agent
    input wire logic snoop_valid_in,
    input wire logic [AW-1:0] snoop_addr_in,
    // conditional store check
    input wire logic cond_valid_in,
    input wire logic [AW-1:0] cond_addr_in,
    // results
    output logic resv_valid_out,
    output logic [AW-1:0] resv_addr_out,
    output logic cond_done_out,
    output logic cond_ok_out
);

    logic resv_ff;
    logic [AW-1:0] addr_ff;
    logic cond_done_ff;
    logic cond_ok_ff;
    logic snoop_hit;
    logic cond_hit;

    // word granule: low two address bits ignored
    assign snoop_hit = resv_ff && (snoop_addr_in[AW-1:2] == addr_ff[AW-1:2]);
    assign cond_hit = resv_ff && (cond_addr_in[AW-1:2] == addr_ff[AW-1:2]);

    // a new reservation wins over a clear arriving in the same cycle
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            resv_ff <= 1'b0;
            addr_ff <= '0;
        end else if (set_in) begin
            resv_ff <= 1'b1;
            addr_ff <= set_addr_in;
        end else if ((snoop_valid_in && snoop_hit) || cond_valid_in) begin
            resv_ff <= 1'b0;
        end
    end

    // store may proceed only if the reservation survived untouched
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cond_done_ff <= 1'b0;
            cond_ok_ff <= 1'b0;
        end else begin
            cond_done_ff <= cond_valid_in;
            cond_ok_ff <= cond_valid_in && cond_hit && !(snoop_valid_in && snoop_hit);
        end
    end

    assign resv_valid_out = resv_ff;
    assign resv_addr_out = addr_ff;
    assign cond_done_out = cond_done_ff;
    assign cond_ok_out = cond_ok_ff;

endmodule // slr_reserve

// ---- verification/slr_mem_model.sv ----
module slr_mem_model #(
    parameter int AW = 64
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // request
    input wire logic req_valid_in,
    input wire logic [AW-1:0] req_addr_in,
    input wire slr_pkg::slr_size_t req_size_in,
    output logic req_ready_out,
    // latency and fault
    input wire logic [3:0] lat_in,
    input wire logic fault_en_in,
    input wire logic [AW-1:0] fault_addr_in,
    // response
    output logic rsp_valid_out,
    output logic [31:0] rsp_data_out,
    output logic rsp_fault_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy_ff, tick_ff, flt_ff;
    logic [3:0] wait_ff;
    logic [31:0] word_ff;
    function automatic logic [7:0] mb(input logic [AW-1:0] a);
        return a[7:0] ^ 8'h5a;
    endfunction
    // slow mode refuses every other cycle
    assign req_ready_out = !busy_ff && (lat_in == 4'h0 || tick_ff);
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {busy_ff, tick_ff, flt_ff, wait_ff, word_ff} <= '0;
            {rsp_valid_out, rsp_data_out, rsp_fault_out} <= '0;
        end else begin
            tick_ff <= ~tick_ff;
            rsp_valid_out <= 1'h0;
            rsp_fault_out <= 1'h0;
            // idle data toggles so stale data is never taken
            rsp_data_out <= ~rsp_data_out;
            if (req_valid_in && req_ready_out) begin
                busy_ff <= 1'h1;
                wait_ff <= lat_in;
                flt_ff <= fault_en_in && req_addr_in == fault_addr_in;
                if (req_size_in == slr_pkg::SLR_SIZE_BYTE) word_ff <= {24'h0, mb(req_addr_in)};
                else word_ff <= {mb(req_addr_in), mb(req_addr_in + 1), mb(req_addr_in + 2), mb(req_addr_in + 3)};
            end else if (busy_ff && wait_ff != 4'h0) begin
                wait_ff <= wait_ff - 4'h1;
            end else if (busy_ff) begin
                busy_ff <= 1'h0;
                rsp_valid_out <= 1'h1;
                rsp_data_out <= word_ff;
                rsp_fault_out <= flt_ff;
            end
        end
    end
endmodule // slr_mem_model

// ---- verification/slr_load_unit_checker.sv ----
module slr_load_unit_checker #(
    parameter int AW = 64
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // command and storage
    input wire logic cmd_valid_in,
    input wire slr_pkg::slr_cmd_t cmd_in,
    input wire logic cmd_ready_out,
    input wire logic mem_req_valid_out,
    input wire logic [AW-1:0] mem_req_addr_out,
    input wire slr_pkg::slr_size_t mem_req_size_out,
    input wire logic mem_req_ready_in,
    input wire logic mem_rsp_valid_in,
    input wire logic mem_rsp_fault_in,
    // results
    input wire slr_pkg::slr_wb_t wb_out,
    input wire logic done_out,
    input wire logic storage_fault_out,
    // reservation
    input wire logic snoop_valid_in,
    input wire logic [AW-1:0] snoop_addr_in,
    input wire logic cond_valid_in,
    input wire logic resv_valid_out,
    input wire logic [AW-1:0] resv_addr_out,
    input wire logic cond_done_out,
    input wire logic cond_ok_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic str_ff;
    logic [AW-1:0] last_ff;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            str_ff <= 1'h0;
            last_ff <= '0;
        end else if (mem_req_valid_out && mem_req_ready_in && mem_req_size_out == slr_pkg::SLR_SIZE_BYTE) begin
            str_ff <= 1'h1;
            last_ff <= mem_req_addr_out;
        end else if (done_out || storage_fault_out) begin
            str_ff <= 1'h0;
        end
    end
    sequence s_zero_take;
        cmd_valid_in && cmd_ready_out && cmd_in.op == slr_pkg::SLR_OP_STR_IDX
            && cmd_in.fixed_point_exception_reg[6:0] == 7'h00;
    endsequence
    sequence s_fault_rsp;
        mem_rsp_valid_in && mem_rsp_fault_in;
    endsequence
    a_req_held: assert property (mem_req_valid_out && !mem_req_ready_in |=> mem_req_valid_out && $stable(mem_req_addr_out))
        else $error("request not held");
    a_addr_ascend: assert property (mem_req_valid_out && mem_req_ready_in && str_ff |-> mem_req_addr_out == last_ff + 1)
        else $error("address not ascending");
    a_str_upper_zero: assert property (wb_out.valid && mem_req_size_out == slr_pkg::SLR_SIZE_BYTE |-> wb_out.data[63:32] == 32'h0)
        else $error("upper half set");
    a_zero_count: assert property (s_zero_take |=> done_out && !wb_out.valid && !mem_req_valid_out)
        else $error("zero count not clean");
    a_fault_abort: assert property (s_fault_rsp |=> storage_fault_out && !done_out ##1 !wb_out.valid [*3])
        else $error("fault not aborted");
    a_cond_answer: assert property (cond_valid_in |=> cond_done_out)
        else $error("no check answer");
    a_cond_noresv: assert property (cond_valid_in && !resv_valid_out |=> !cond_ok_out)
        else $error("unreserved check passed");
    a_snoop_clears: assert property (snoop_valid_in && !mem_rsp_valid_in
        && snoop_addr_in[AW-1:2] == resv_addr_out[AW-1:2] |=> !resv_valid_out)
        else $error("reservation kept");
endmodule // slr_load_unit_checker

bind slr_load_unit slr_load_unit_checker #(.AW(AW)) u_chk (.clk_in, .rst_n_in, .cmd_valid_in, .cmd_in,
    .cmd_ready_out, .mem_req_valid_out, .mem_req_addr_out, .mem_req_size_out, .mem_req_ready_in,
    .mem_rsp_valid_in, .mem_rsp_fault_in, .wb_out, .done_out, .storage_fault_out, .snoop_valid_in,
    .snoop_addr_in, .cond_valid_in, .resv_valid_out, .resv_addr_out, .cond_done_out, .cond_ok_out);

// ---- verification/slr_load_unit_bench.sv ----
module slr_load_unit_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int AW = 64;
    logic clk_in, rst_n_in, cmd_valid_in, cmd_ready_out, mem_req_valid_out, mem_req_ready_in, mem_rsp_valid_in;
    logic mem_rsp_fault_in, done_out, illegal_out, storage_fault_out, snoop_valid_in, cond_valid_in;
    logic resv_valid_out, cond_done_out, cond_ok_out, fault_en, seen_done, seen_fault;
    logic [AW-1:0] base_val_in, index_val_in, mem_req_addr_out, snoop_addr_in, cond_addr_in, resv_addr_out, fault_addr;
    logic [31:0] mem_rsp_data_in;
    logic [3:0] lat;
    slr_pkg::slr_cmd_t cmd_in;
    slr_pkg::slr_size_t mem_req_size_out;
    slr_pkg::slr_wb_t wb_out;
    slr_pkg::slr_wb_t wb_q[$];
    logic [AW-1:0] addr_q[$];
    int n_fail, cmp_count;
    slr_load_unit #(.AW(AW), .IS_64BIT(1'h1)) DUT (.clk_in, .rst_n_in, .cmd_valid_in, .cmd_in, .base_val_in,
        .index_val_in, .cmd_ready_out, .mem_req_valid_out, .mem_req_addr_out, .mem_req_size_out, .mem_req_ready_in,
        .mem_rsp_valid_in, .mem_rsp_data_in, .mem_rsp_fault_in, .wb_out, .done_out, .illegal_out, .storage_fault_out,
        .snoop_valid_in, .snoop_addr_in, .cond_valid_in, .cond_addr_in, .resv_valid_out, .resv_addr_out,
        .cond_done_out, .cond_ok_out);
    slr_mem_model #(.AW(AW)) MEM (.clk_in, .rst_n_in, .req_valid_in(mem_req_valid_out),
        .req_addr_in(mem_req_addr_out), .req_size_in(mem_req_size_out), .req_ready_out(mem_req_ready_in),
        .lat_in(lat), .fault_en_in(fault_en), .fault_addr_in(fault_addr), .rsp_valid_out(mem_rsp_valid_in),
        .rsp_data_out(mem_rsp_data_in), .rsp_fault_out(mem_rsp_fault_in));
    initial begin
        clk_in = 1'h0;
        forever #2 clk_in = ~clk_in;
    end
    always @(negedge clk_in) begin
        if (wb_out.valid === 1'h1) wb_q.push_back(wb_out);
        if (mem_req_valid_out === 1'h1 && mem_req_ready_in === 1'h1) addr_q.push_back(mem_req_addr_out);
        if (done_out === 1'h1) seen_done = 1'h1;
        if (storage_fault_out === 1'h1) seen_fault = 1'h1;
    end
    function automatic logic [7:0] mb(input logic [AW-1:0] a);
        return a[7:0] ^ 8'h5a;
    endfunction
    task automatic chk(input string what, input logic [69:0] exp, input logic [69:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic issue(input slr_pkg::slr_cmd_t c, input logic [AW-1:0] bv, input logic [AW-1:0] iv);
        @(negedge clk_in);
        while (cmd_ready_out !== 1'h1) @(negedge clk_in);
        @(posedge clk_in);
        cmd_valid_in <= 1'h1;
        cmd_in <= c;
        base_val_in <= bv;
        index_val_in <= iv;
        @(posedge clk_in);
        cmd_valid_in <= 1'h0;
        wb_q.delete();
        addr_q.delete();
        seen_done = 1'h0;
        seen_fault = 1'h0;
        for (int i = 0; i < 600 && !(seen_done || seen_fault); i++) @(negedge clk_in);
    endtask
    task automatic check_str(input logic [4:0] t, input int n, input logic [AW-1:0] ea, input logic [31:0] skip);
        slr_pkg::slr_wb_t e[$];
        logic [4:0] g;
        logic [31:0] w;
        for (int r = 0; r < (n + 3) / 4; r++) begin
            g = t + 5'(r);
            w = 32'h0;
            for (int l = 0; l < 4; l++) if (4 * r + l < n) w[31 - 8 * l -: 8] = mb(ea + AW'(4 * r + l));
            if (!skip[g]) e.push_back({1'h1, g, 32'h0, w});
        end
        chk("writes", e.size(), wb_q.size());
        foreach (e[i]) if (i < wb_q.size()) chk("write", e[i], wb_q[i]);
        chk("bytes", n, addr_q.size());
        foreach (addr_q[k]) chk("byte addr", ea + AW'(k), addr_q[k]);
        chk("done", 1, seen_done);
    endtask
    task automatic check_word(input logic [4:0] t, input logic [AW-1:0] ea, input logic sx);
        logic [31:0] w;
        w = {mb(ea), mb(ea + 1), mb(ea + 2), mb(ea + 3)};
        chk("word addr", ea, addr_q[0]);
        chk("word wb", {1'h1, t, {32{sx & w[31]}}, w}, wb_q[0]);
    endtask
    task automatic t_imm_wrap;
        issue('{slr_pkg::SLR_OP_STR_IMM, 1'h1, 5'h1e, 5'h05, 5'h00, 5'h00, 16'h0, 32'h0}, 64'h1000, 64'h0);
        check_str(5'h1e, 32, 64'h1000, 32'h0000_0020);
    endtask
    task automatic t_imm_base_zero;
        issue('{slr_pkg::SLR_OP_STR_IMM, 1'h1, 5'h06, 5'h00, 5'h1f, 5'h06, 16'h0, 32'h0}, 64'h7770, 64'h0);
        check_str(5'h06, 6, 64'h0, 32'h0);
    endtask
    task automatic t_idx_legacy;
        issue('{slr_pkg::SLR_OP_STR_IDX, 1'h1, 5'h02, 5'h03, 5'h02, 5'h00, 16'h0, 32'hffff_ff8a}, 64'h2000, 64'h30);
        check_str(5'h02, 10, 64'h2030, 32'h0000_000c);
    endtask
    task automatic t_idx_zero;
        issue('{slr_pkg::SLR_OP_STR_IDX, 1'h0, 5'h08, 5'h01, 5'h02, 5'h00, 16'h0, 32'hffff_ff80}, 64'h10, 64'h20);
        chk("zc writes", 0, wb_q.size());
        chk("zc reqs", 0, addr_q.size());
        chk("zc done", 1, seen_done);
    endtask
    task automatic t_fault_restart;
        slr_pkg::slr_cmd_t c;
        c = '{slr_pkg::SLR_OP_STR_IDX, 1'h0, 5'h0a, 5'h00, 5'h07, 5'h00, 16'h0, 32'h8};
        @(posedge clk_in);
        lat <= 4'h3;
        fault_en <= 1'h1;
        fault_addr <= 64'h4002;
        issue(c, 64'h0, 64'h4000);
        chk("fault", 1, seen_fault);
        chk("fault wb", 0, wb_q.size());
        chk("fault reqs", 3, addr_q.size());
        fault_en <= 1'h0;
        issue(c, 64'h0, 64'h4000);
        check_str(5'h0a, 8, 64'h4000, 32'h0);
        lat <= 4'h0;
    endtask
    task automatic pulse(input logic snoop, input logic [AW-1:0] a, input logic ok);
        @(posedge clk_in);
        snoop_valid_in <= snoop;
        cond_valid_in <= !snoop;
        snoop_addr_in <= a;
        cond_addr_in <= a;
        @(posedge clk_in);
        snoop_valid_in <= 1'h0;
        cond_valid_in <= 1'h0;
        @(negedge clk_in);
        if (!snoop) chk("cond", {1'h1, ok}, {cond_done_out, cond_ok_out});
    endtask
    task automatic t_words;
        issue('{slr_pkg::SLR_OP_WORD_ALG, 1'h0, 5'h11, 5'h00, 5'h00, 5'h00, 16'h0080, 32'h0}, 64'h9990, 64'h0);
        check_word(5'h11, 64'h80, 1'h1);
        issue('{slr_pkg::SLR_OP_WORD_RSV, 1'h0, 5'h03, 5'h04, 5'h05, 5'h00, 16'h0, 32'h0}, 64'h100, 64'hc0);
        check_word(5'h03, 64'h1c0, 1'h0);
        chk("resv", {1'h1, 64'h1c0}, {resv_valid_out, resv_addr_out});
        pulse(1'h0, 64'h1c0, 1'h1);
        pulse(1'h0, 64'h1c0, 1'h0);
        issue('{slr_pkg::SLR_OP_WORD_RSV, 1'h0, 5'h03, 5'h00, 5'h05, 5'h00, 16'h0, 32'h0}, 64'h100, 64'hc0);
        check_word(5'h03, 64'hc0, 1'h0);
        pulse(1'h1, 64'hc2, 1'h0);
        pulse(1'h0, 64'hc0, 1'h0);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (8000) @(posedge clk_in);
        n_fail++;
        print_verdict;
    end
    initial begin
        {rst_n_in, cmd_valid_in, snoop_valid_in, cond_valid_in, fault_en} = 5'h0;
        {cmd_in, base_val_in, index_val_in, snoop_addr_in, cond_addr_in, fault_addr, lat} = '0;
        {n_fail, cmp_count} = '0;
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'h1;
        t_imm_wrap;
        t_imm_base_zero;
        t_idx_legacy;
        t_idx_zero;
        t_fault_restart;
        t_words;
        print_verdict;
    end
endmodule // slr_load_unit_bench
